// file: hw/vdo_pkg.sv
// Shared constants and carrier types for the video output timing block.
// Assumes a 50 MHz system clock and a sampled 27 MHz pixel link clock.
package vdo_pkg;

  localparam int unsigned CLK_HZ  = 50_000_000;
  localparam int unsigned LINK_HZ = 27_000_000;

  // Wishbone byte addresses.
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_ISTAT  = 8'h08;
  localparam logic [7:0] ADR_IMASK  = 8'h0C;
  localparam logic [7:0] ADR_LINE   = 8'h10;

  // Control register fields.
  localparam int                CTRL_W        = 5;
  localparam int                CTL_EN        = 0;
  localparam int                CTL_VB_SEL    = 1;
  localparam int                CTL_LOCK_SEL  = 2;
  localparam int                CTL_COMPOSITE_SYNC_OUT_SEL = 3;
  localparam int                CTL_SYS625    = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST      = 5'h01;

  // Status register fields.
  localparam int ST_NO_INPUT_FLAG  = 0;
  localparam int ST_NONSTANDARD_INPUT_FLAG  = 1;
  localparam int ST_VERTICAL_LOCK_STATUS = 2;
  localparam int ST_PD    = 3;
  localparam int ST_FIELD = 4;

  // Interrupt status and mask fields.
  localparam int IRQ_W     = 4;
  localparam int IRQ_FIELD = 0;
  localparam int IRQ_NOSIG = 1;
  localparam int IRQ_NONSTANDARD_INPUT_FLAG  = 2;
  localparam int IRQ_PD    = 3;

  // Line and frame geometry, in bytes and lines.
  localparam logic [10:0] H_TOTAL_525 = 11'h6B4;
  localparam logic [10:0] H_TOTAL_625 = 11'h6C0;
  localparam logic [10:0] TRS_LEN     = 11'h004;
  localparam logic [10:0] HS_BYTES    = 11'h080;
  localparam logic [9:0]  LINES_525   = 10'h20D;
  localparam logic [9:0]  LINES_625   = 10'h271;
  localparam logic [9:0]  VBL_525     = 10'h014;
  localparam logic [9:0]  VBL_625     = 10'h018;
  localparam logic [9:0]  VS_LINES    = 10'h003;

  // Stream byte values.
  localparam logic [7:0] TRS_FF  = 8'hFF;
  localparam logic [7:0] TRS_00  = 8'h00;
  localparam logic [7:0] BLANK_C = 8'h80;
  localparam logic [7:0] BLANK_Y = 8'h10;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } vdo_wb_req_t;

  typedef struct packed {
    logic no_input;
    logic nonstd;
    logic vertical_lock_status;
  } vdo_vid_stat_t;

  typedef struct packed {
    logic [7:0] cb;
    logic [7:0] y;
    logic [7:0] cr;
  } vdo_pix_t;

endpackage : vdo_pkg

// file: hw/vdo_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is an independent level; no bit relation survives the crossing.
module vdo_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } vdo_sync_st_t;

  vdo_sync_st_t st_reg;
  vdo_sync_st_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;

endmodule : vdo_sync

// file: hw/vdo_output_timing.sv
// Output timing of the video decoder: 4:2:2 byte stream with timing codes and status pins.
// Assumes a 50 MHz clk_i, a Wishbone classic master and a sampled 27 MHz link clock pin.
// What this block does
// - Bytes leave as an 8-bit 4:2:2 stream framed by end and start of active video codes.
// - The stream advances on the 27 MHz link clock that the outside party supplies.
// - A control bit turns the vertical sync pin into a vertical blanking signal.
// - The active video pin is high for the 720 pixels of each line.
// - A control bit turns the active video pin into the vertical lock status.
// - With a standard input the two frame pins show the colour frame sequence.
// - With a non-standard input the frame pins toggle once every 525 or 625 lines.
// - A control bit turns the upper frame pin into composite sync.
// - A half-rate marker tells whether each byte of the stream is luma or chroma.
// - An output clock of about 27 MHz times each byte on the data pins.
// - The polarity pin sets the polarity of that output clock.
// - The no-signal pin is high while no video is present.
// - The non-standard pin is high while the input is non-standard.
// - A high power-down pin stops the stream and the output clock until the next reset; the bus, status pins and interrupt keep working.
module vdo_output_timing #(
  parameter int ACTIVE_PIXELS = 720
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire vdo_pkg::vdo_wb_req_t   wb_i,
  output logic                        wb_ack_o,
  output logic [31:0]                 wb_dat_o,
  input  wire logic                   video_clk_i,
  input  wire logic                   power_down_in_i,
  input  wire logic                   out_clock_polarity_sel_i,
  input  wire vdo_pkg::vdo_vid_stat_t stat_i,
  input  wire vdo_pkg::vdo_pix_t      pix_i,
  output logic [7:0]                  data_o,
  output logic                        pixel_clock_out_o,
  output logic                        luma_chroma_phase_o,
  output logic                        hsync_o,
  output logic                        vsync_o,
  output logic                        active_video_flag_o,
  output logic                        color_frame_out_hi_o,
  output logic                        color_frame_out_lo_o,
  output logic                        no_input_flag_o,
  output logic                        nonstandard_input_flag_o,
  output logic                        irq_o
);
  import vdo_pkg::*;

  localparam logic [10:0] ACT_B = 11'(2 * ACTIVE_PIXELS);

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0]  imask;
    logic [IRQ_W-1:0]  istat;
    logic              ack;
    logic [31:0]       rdat;
    logic [10:0]       hcnt;
    logic [9:0]        vcnt;
    logic [1:0]        fcnt;
    logic              ns_tog;
    logic              pd_lat;
    logic              lclk_d;
    logic [7:0]        data;
    logic              pclk;
    logic              phase;
    logic              hs;
    logic              vs;
    logic              av;
    logic              fhi;
    logic              flo;
    logic              no_input_flag;
    logic              nonstandard_input_flag;
    logic              irq;
  } vdo_state_t;

  localparam vdo_state_t ST_RST = '{ctrl: CTRL_RST, default: '0};

  vdo_state_t st_reg;
  vdo_state_t st_next;

  logic [2:0] sy;
  logic       lclk_s;
  logic       pd_s;
  logic       pol_s;

  // Link clock, power-down and polarity pins all come from outside this clock domain.
  vdo_sync #(.W(3)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({video_clk_i, power_down_in_i, out_clock_polarity_sel_i}),
    .q_o   (sy)
  );
  assign lclk_s = sy[2];
  assign pd_s   = sy[1];
  assign pol_s  = sy[0];

  logic        sys625;
  logic [10:0] htot;
  logic [9:0]  lines;
  logic [9:0]  half;
  logic [9:0]  vbl;
  logic        run;
  logic        tick;
  logic        fld;
  logic        vb;
  logic        vs_raw;
  logic        eav;
  logic        sav;
  logic        hs_raw;
  logic        h_wrap;
  logic        v_wrap;
  logic        acc;

  assign sys625 = st_reg.ctrl[CTL_SYS625];
  assign htot   = sys625 ? H_TOTAL_625 : H_TOTAL_525;
  assign lines  = sys625 ? LINES_625 : LINES_525;
  assign vbl    = sys625 ? VBL_625 : VBL_525;
  assign half   = 10'((lines + 10'h001) >> 1);
  assign run    = st_reg.ctrl[CTL_EN] & ~st_reg.pd_lat;
  // The stream advances once per rising edge of the sampled link clock.
  assign tick   = lclk_s & ~st_reg.lclk_d;
  assign fld    = st_reg.vcnt >= half;
  assign vb     = (st_reg.vcnt < vbl) | (fld & (st_reg.vcnt < half + vbl));
  assign vs_raw = (st_reg.vcnt < VS_LINES) | (fld & (st_reg.vcnt < half + VS_LINES));
  assign eav    = (st_reg.hcnt >= ACT_B) & (st_reg.hcnt < ACT_B + TRS_LEN);
  assign sav    = st_reg.hcnt >= htot - TRS_LEN;
  assign hs_raw = (st_reg.hcnt >= ACT_B + TRS_LEN) & (st_reg.hcnt < ACT_B + TRS_LEN + HS_BYTES);
  assign h_wrap = st_reg.hcnt == htot - 11'h001;
  assign v_wrap = st_reg.vcnt == lines - 10'h001;
  assign acc    = wb_i.cyc & wb_i.stb & ~st_reg.ack;

  always_comb begin
    logic [7:0]       byte_v;
    logic [7:0]       xy;
    logic [IRQ_W-1:0] ev;
    logic             clr;
    byte_v  = BLANK_C;
    xy      = '0;
    ev      = '0;
    clr     = 1'b0;
    st_next = st_reg;
    st_next.lclk_d = lclk_s;

    // Bus slave: every access is answered one cycle after it is taken.
    st_next.ack = acc;
    if (acc) begin
      unique case (wb_i.adr)
        ADR_CTRL:   st_next.rdat = 32'(st_reg.ctrl);
        ADR_STATUS: st_next.rdat = 32'({fld, st_reg.pd_lat, stat_i.vertical_lock_status,
                                        st_reg.nonstandard_input_flag, st_reg.no_input_flag});
        ADR_ISTAT:  st_next.rdat = 32'(st_reg.istat);
        ADR_IMASK:  st_next.rdat = 32'(st_reg.imask);
        ADR_LINE:   st_next.rdat = 32'(st_reg.vcnt);
        default:    st_next.rdat = '0;
      endcase
      if (wb_i.we && wb_i.sel[0]) begin
        if (wb_i.adr == ADR_CTRL) begin
          st_next.ctrl = wb_i.dat[CTRL_W-1:0];
        end
        if (wb_i.adr == ADR_IMASK) begin
          st_next.imask = wb_i.dat[IRQ_W-1:0];
        end
      end
      clr = ~wb_i.we & (wb_i.adr == ADR_ISTAT);
    end

    // Power-down latches until reset so the stream restarts cleanly.
    if (pd_s) begin
      st_next.pd_lat = 1'b1;
    end
    ev[IRQ_PD] = pd_s & ~st_reg.pd_lat;

    xy = {1'b1, fld, vb, eav, vb ^ eav, fld ^ eav, fld ^ vb, fld ^ vb ^ eav};
    if (st_reg.hcnt < ACT_B) begin
      if (vb) begin
        byte_v = st_reg.hcnt[0] ? BLANK_Y : BLANK_C;
      end else begin
        unique case (st_reg.hcnt[1:0])
          2'h0:    byte_v = pix_i.cb;
          2'h2:    byte_v = pix_i.cr;
          default: byte_v = pix_i.y;
        endcase
      end
    end else if (eav || sav) begin
      unique case (st_reg.hcnt[1:0])
        2'h0:    byte_v = TRS_FF;
        2'h3:    byte_v = xy;
        default: byte_v = TRS_00;
      endcase
    end else begin
      byte_v = st_reg.hcnt[0] ? BLANK_Y : BLANK_C;
    end

    if (!run) begin
      st_next.data  = '0;
      st_next.phase = 1'b0;
      st_next.hs    = 1'b0;
      st_next.vs    = 1'b0;
      st_next.av    = 1'b0;
      st_next.fhi   = 1'b0;
      st_next.flo   = 1'b0;
    end else if (tick) begin
      st_next.data  = byte_v;
      st_next.phase = st_reg.hcnt[0];
      st_next.hs    = hs_raw;
      st_next.vs    = st_reg.ctrl[CTL_VB_SEL] ? vb : vs_raw;
      st_next.av    = st_reg.hcnt < ACT_B;
      if (st_reg.nonstandard_input_flag) begin
        st_next.flo = st_reg.ns_tog;
        st_next.fhi = st_reg.ns_tog;
      end else begin
        st_next.flo = st_reg.fcnt[0];
        st_next.fhi = st_reg.fcnt[1];
      end
      if (st_reg.ctrl[CTL_COMPOSITE_SYNC_OUT_SEL]) begin
        st_next.fhi = hs_raw | vs_raw;
      end
      st_next.hcnt = h_wrap ? '0 : st_reg.hcnt + 11'h001;
      if (h_wrap) begin
        st_next.vcnt = v_wrap ? '0 : st_reg.vcnt + 10'h001;
        if (v_wrap || st_reg.vcnt == half - 10'h001) begin
          st_next.fcnt    = st_reg.fcnt + 2'h1;
          ev[IRQ_FIELD]   = 1'b1;
        end
        if (v_wrap) begin
          st_next.ns_tog = ~st_reg.ns_tog;
        end
      end
    end
    if (st_reg.ctrl[CTL_LOCK_SEL]) begin
      st_next.av = stat_i.vertical_lock_status;
    end

    st_next.pclk = run & (lclk_s ^ pol_s);
    st_next.no_input_flag = stat_i.no_input;
    st_next.nonstandard_input_flag = stat_i.nonstd;
    ev[IRQ_NOSIG] = stat_i.no_input & ~st_reg.no_input_flag;
    ev[IRQ_NONSTANDARD_INPUT_FLAG]  = stat_i.nonstd ^ st_reg.nonstandard_input_flag;

    // A new event wins over the read that clears the status.
    st_next.istat = (clr ? '0 : st_reg.istat) | ev;
    st_next.irq   = |(st_next.istat & st_next.imask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o                 = st_reg.ack;
  assign wb_dat_o                 = st_reg.rdat;
  assign data_o                   = st_reg.data;
  assign pixel_clock_out_o        = st_reg.pclk;
  assign luma_chroma_phase_o      = st_reg.phase;
  assign hsync_o                  = st_reg.hs;
  assign vsync_o                  = st_reg.vs;
  assign active_video_flag_o      = st_reg.av;
  assign color_frame_out_hi_o     = st_reg.fhi;
  assign color_frame_out_lo_o     = st_reg.flo;
  assign no_input_flag_o          = st_reg.no_input_flag;
  assign nonstandard_input_flag_o = st_reg.nonstandard_input_flag;
  assign irq_o                    = st_reg.irq;

  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sav_preamble: assert property (tick && run && st_reg.hcnt == htot - TRS_LEN
    |=> data_o == TRS_FF) else $error("start code does not open with FF");
  a_eav_flag: assert property (tick && run && st_reg.hcnt == ACT_B + 11'h003
    |=> data_o[7] && data_o[4]) else $error("end code lacks the H bit");
  a_vblank_route: assert property (tick && run && st_reg.ctrl[CTL_VB_SEL]
    |=> vsync_o == $past(vb)) else $error("vertical pin not blanking");
  a_active_span: assert property (tick && run && !st_reg.ctrl[CTL_LOCK_SEL]
    && st_reg.hcnt == ACT_B |=> !active_video_flag_o) else $error("active too long");
  a_lock_route: assert property (st_reg.ctrl[CTL_LOCK_SEL]
    |=> active_video_flag_o == $past(stat_i.vertical_lock_status)) else $error("lock not routed");
  a_ns_toggle: assert property (tick && run && st_reg.nonstandard_input_flag && h_wrap && v_wrap
    |=> st_reg.ns_tog != $past(st_reg.ns_tog)) else $error("frame toggle missing");
  a_composite_sync_out_route: assert property (tick && run && st_reg.ctrl[CTL_COMPOSITE_SYNC_OUT_SEL]
    |=> color_frame_out_hi_o == $past(hs_raw | vs_raw)) else $error("composite_sync_out wrong");
  a_phase_mark: assert property (tick && run
    |=> luma_chroma_phase_o == $past(st_reg.hcnt[0])) else $error("phase wrong");
  a_clk_polarity: assert property (run ##1 run
    |-> pixel_clock_out_o == $past(lclk_s ^ pol_s)) else $error("clock polarity");
  a_no_input_flag_follow: assert property (##1 1'b1
    |-> no_input_flag_o == $past(stat_i.no_input)) else $error("no-signal pin");
  a_nonstandard_input_flag_follow: assert property (##1 1'b1
    |-> nonstandard_input_flag_o == $past(stat_i.nonstd)) else $error("nonstandard_input_flag pin");
  a_pd_quiet: assert property (st_reg.pd_lat
    |=> data_o == TRS_00 && !luma_chroma_phase_o) else $error("stream in power-down");
  a_cb_first: assert property (tick && run && !vb && st_reg.hcnt[1:0] == 2'h0
    && st_reg.hcnt < ACT_B |=> data_o == $past(pix_i.cb)) else $error("Cb order");

  c_line_wrap: cover property (tick && run && h_wrap);
  c_frame_wrap: cover property (tick && run && h_wrap && v_wrap);
  c_irq_raise: cover property (!irq_o ##1 irq_o);
  c_power_down: cover property ($rose(st_reg.pd_lat));

endmodule : vdo_output_timing

// file: dv/vdo_rx_model.sv
// Receiver model that stands downstream of the video output timing block.
// Assumes the block's stream pins and the bench's clock and reset.
module vdo_rx_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        pol_i,
  input  wire logic        pck_i,
  input  wire logic [7:0]  d_i,
  input  wire logic        av_i,
  input  wire logic        ph_i,
  output logic      [15:0] lines_o,
  output logic      [15:0] len_o,
  output logic      [15:0] av_o,
  output logic      [15:0] err_o
);
  logic [23:0] hist;
  logic [15:0] cnt;
  logic [15:0] avc;
  logic [15:0] idx;
  logic [3:0]  polh;
  logic        pck_q;
  logic        ph_q;
  logic [7:0]  want;
  logic [7:0]  blank;
  logic        cap;
  logic        e_edge;
  logic        e_ord;
  logic        e_code;

  // Bytes are taken on the edge the polarity pin selects, never while the pin settles.
  assign cap = pck_q != pol_i && pck_i == pol_i && (&polh || ~|polh);
  assign want = idx[0] ? 8'h50 : (idx[1] ? 8'h60 : 8'h40);
  assign e_edge = ph_i != ph_q && pck_i == pol_i && (&polh || ~|polh);
  // Vertical blank lines keep the active flag high but carry blanking bytes.
  assign blank = idx[0] ? 8'h10 : 8'h80;
  assign e_ord = cap && av_i && ((d_i != want && d_i != blank) || ph_i != idx[0]);
  assign e_code = cap && hist == 24'hFF0000 && (!d_i[7] || d_i[3:0] !=
                  {d_i[5] ^ d_i[4], d_i[6] ^ d_i[4], d_i[6] ^ d_i[5], ^d_i[6:4]});

  always_ff @(posedge clk_i) begin
    pck_q <= pck_i;
    ph_q <= ph_i;
    polh <= {polh[2:0], pol_i};
    err_o <= rst_i ? 16'h0 : err_o + 16'(e_edge) + 16'(e_ord) + 16'(e_code);
    if (rst_i) begin
      lines_o <= '0;
      len_o <= '0;
      av_o <= '0;
      cnt <= '0;
      avc <= '0;
      idx <= '0;
      hist <= '0;
    end else if (cap) begin
      hist <= {hist[15:0], d_i};
      cnt <= cnt + 16'h1;
      avc <= avc + 16'(av_i);
      idx <= av_i ? idx + 16'h1 : 16'h0;
      // A start code closes one line and opens the next.
      if (hist == 24'hFF0000 && !d_i[4]) begin
        lines_o <= lines_o + 16'h1;
        len_o <= cnt + 16'h1;
        av_o <= avc;
        cnt <= 16'h0;
        avc <= 16'h0;
      end
    end
  end
endmodule : vdo_rx_model

// file: dv/vdo_output_timing_test.sv
// Self-checking bench for the video output timing block.
// Assumes the package, the timing block and the receiver model are compiled first.
module vdo_output_timing_test;
  timeunit 1ns;
  timeprecision 1ns;
  import vdo_pkg::*;

  typedef struct packed {
    logic        we;
    logic [7:0]  a;
    logic [3:0]  s;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } vdo_row_t;

  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          vclk  = 1'b0;
  logic          pd    = 1'b0;
  logic          pol   = 1'b0;
  vdo_wb_req_t   wb    = '0;
  vdo_vid_stat_t st    = 3'h1;
  vdo_pix_t      px    = 24'h405060;
  logic [31:0]   rdat;
  logic [31:0]   wb_dat;
  logic [7:0]    dat;
  logic          wb_ack, pck, ph, hs, vs, av, fhi, flo, no_input_flag, nonstandard_input_flag, irq;
  logic [15:0]   m_lines, m_len, m_av, m_err;
  int            fails = 0;
  int            n_checks = 0;
  int            bad;

  vdo_row_t rows [8] = '{
    '{1'b0, ADR_CTRL, 4'hF, 32'h0, 32'h1F, 32'h1},
    '{1'b1, ADR_CTRL, 4'h2, 32'h1E, 32'h0, 32'h0},
    '{1'b0, ADR_CTRL, 4'hF, 32'h0, 32'h1F, 32'h1},
    '{1'b1, ADR_IMASK, 4'hF, 32'h2, 32'h0, 32'h0},
    '{1'b0, ADR_IMASK, 4'hF, 32'h0, 32'hF, 32'h2},
    '{1'b1, 8'h20, 4'hF, 32'hFF, 32'h0, 32'h0},
    '{1'b0, 8'h20, 4'hF, 32'h0, 32'hFFFFFFFF, 32'h0},
    '{1'b0, ADR_STATUS, 4'hF, 32'h0, 32'hF, 32'h4}
  };

  initial forever #10 clk_i = ~clk_i;

  initial begin
    #37;
    forever #80 vclk = ~vclk;
  end

  vdo_output_timing dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(wb_ack), .wb_dat_o(wb_dat),
    .video_clk_i(vclk), .power_down_in_i(pd), .out_clock_polarity_sel_i(pol),
    .stat_i(st), .pix_i(px), .data_o(dat), .pixel_clock_out_o(pck),
    .luma_chroma_phase_o(ph), .hsync_o(hs), .vsync_o(vs), .active_video_flag_o(av),
    .color_frame_out_hi_o(fhi), .color_frame_out_lo_o(flo), .no_input_flag_o(no_input_flag),
    .nonstandard_input_flag_o(nonstandard_input_flag), .irq_o(irq)
  );

  vdo_rx_model rx_u (
    .clk_i(clk_i), .rst_i(rst_i), .pol_i(pol), .pck_i(pck), .d_i(dat), .av_i(av),
    .ph_i(ph), .lines_o(m_lines), .len_o(m_len), .av_o(m_av), .err_o(m_err)
  );

  task automatic give_verdict();
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic give_up();
    fails++;
    give_verdict();
  endtask : give_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [3:0] s,
                         input logic [31:0] d);
    int n;
    n = 0;
    wb <= '{1'b1, 1'b1, we, a, s, d};
    do begin
      @(posedge clk_i);
      if (++n > 50) give_up();
    end while (wb_ack !== 1'b1);
    rdat = wb_dat;
    wb <= '0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic wait_for(input int w, input logic v);
    int n;
    n = 0;
    while ((w == 0 ? av : (w == 1 ? hs : pck)) !== v) begin
      @(posedge clk_i);
      if (++n > 15000) give_up();
    end
  endtask : wait_for

  task automatic wait_lines(input int k);
    int n;
    int base;
    n = 0;
    base = m_lines;
    while (m_lines < base + k) begin
      @(posedge clk_i);
      if (++n > 30000) give_up();
    end
  endtask : wait_lines

  // Thirty cycles cover three link ticks through the synchroniser.
  task automatic settle();
    repeat (30) @(posedge clk_i);
  endtask : settle

  initial begin
    repeat (100000) @(posedge clk_i);
    give_up();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      wb_xfer(rows[i].we, rows[i].a, rows[i].s, rows[i].d);
      if (!rows[i].we) chk("register read", rows[i].e, rdat & rows[i].m);
    end
    wait_lines(2);
    chk("line length", 32'h6B4, 32'(m_len));
    chk("active bytes", 32'h5A0, 32'(m_av));
    wait_for(0, 1'b0);
    pol <= 1'b1;
    wait_lines(2);
    chk("receiver faults", 32'h0, 32'(m_err));
    wb_xfer(1'b1, ADR_CTRL, 4'hF, 32'h3);
    settle();
    chk("vertical blank", 32'h1, 32'(vs));
    wb_xfer(1'b1, ADR_CTRL, 4'hF, 32'h1);
    settle();
    chk("vertical sync", 32'h0, 32'(vs));
    wb_xfer(1'b1, ADR_CTRL, 4'hF, 32'h5);
    st.vertical_lock_status <= 1'b0;
    settle();
    chk("lock on active pin", 32'h0, 32'(av));
    st.vertical_lock_status <= 1'b1;
    settle();
    chk("lock on active pin", 32'h1, 32'(av));
    wb_xfer(1'b1, ADR_CTRL, 4'hF, 32'h9);
    wait_for(1, 1'b0);
    wait_for(1, 1'b1);
    repeat (2) @(posedge clk_i);
    chk("composite sync", 32'h1, 32'(fhi));
    wb_xfer(1'b1, ADR_CTRL, 4'hF, 32'h11);
    wait_lines(2);
    chk("line length", 32'h6C0, 32'(m_len));
    st.no_input <= 1'b1;
    st.nonstd <= 1'b1;
    settle();
    chk("no signal pin", 32'h1, 32'(no_input_flag));
    chk("non-standard pin", 32'h1, 32'(nonstandard_input_flag));
    chk("frame pins equal", 32'(fhi), 32'(flo));
    chk("interrupt", 32'h1, 32'(irq));
    wb_xfer(1'b0, ADR_ISTAT, 4'hF, 32'h0);
    chk("event status", 32'h2, rdat & 32'h2);
    settle();
    chk("cleared interrupt", 32'h0, 32'(irq));
    wb_xfer(1'b1, ADR_IMASK, 4'hF, 32'h0);
    st.no_input <= 1'b0;
    settle();
    st.no_input <= 1'b1;
    settle();
    chk("masked interrupt", 32'h0, 32'(irq));
    wb_xfer(1'b1, ADR_IMASK, 4'hF, 32'h2);
    settle();
    chk("unmasked interrupt", 32'h1, 32'(irq));
    pd <= 1'b1;
    settle();
    bad = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (dat !== 8'h0 || pck !== 1'b0) bad++;
    end
    chk("stopped stream", 32'h0, 32'(bad));
    wb_xfer(1'b0, ADR_STATUS, 4'hF, 32'h0);
    chk("power-down status", 32'h8, rdat & 32'h8);
    pd <= 1'b0;
    settle();
    chk("power-down latch", 32'h0, 32'(pck));
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb_xfer(1'b0, ADR_CTRL, 4'hF, 32'h0);
    chk("control after reset", 32'h1, rdat & 32'h1F);
    wait_for(2, 1'b1);
    give_verdict();
  end
endmodule : vdo_output_timing_test
